/* File: uart_efc_regs.svh */
`ifndef UART_EFC_REGS_SVH
`define UART_EFC_REGS_SVH

// Register indices on the register port
`define A_IER 5'h01
`define A_ISR 5'h02
`define A_FCR 5'h03
`define A_MCR 5'h04
`define A_LSR 5'h05
`define A_MSR 5'h06
`define A_SPR 5'h07
`define A_DLL 5'h08
`define A_DLM 5'h09
`define A_DLD 5'h0a
`define A_EFR 5'h0b
`define A_TCR 5'h0c
`define A_TLR 5'h0d
`define A_XON_CHAR_ONE 5'h0e
`define A_XON_CHAR_TWO 5'h0f
`define A_XOFF_CHAR_ONE 5'h10
`define A_XOFF_CHAR_TWO 5'h11
`define A_IOCTL 5'h12

// Masks of bits that only change while enhanced functions are enabled
`define M_IER 8'hf0
`define M_ISR 8'h30
`define M_FCR 8'h30
`define M_MCR 8'he0
`define M_ALL 8'hff

// Field positions
`define B_EFR_ENH 4
`define B_EFR_SPC 5
`define B_EFR_ARTS 6
`define B_EFR_ACTS 7
`define B_MCR_DTR 0
`define B_MCR_RTS 1
`define B_IER_RXD 0
`define B_IER_SPC 5
`define B_IOCTL_SRST 3
`define RXFC_PAIR1 2'b10
`define RXFC_PAIR2 2'b01
`define RXFC_BOTH 2'b11

// Reset values
`define R_ZERO 8'h00
`define R_ISR 8'h01
`define R_LSR 8'h60
`define R_TCR 8'h0f
`define R_DLL 8'h01
`define R_DLM 8'h00
`define R_SPR 8'hff
`define R_XCHR 8'h00

// Levels in the level registers count groups of four entries
`define LVL_SHIFT 2

`endif

/* File: uart_efc_pkg.sv */
package uart_efc_pkg;

	// Registers that survive hardware and software reset
	typedef struct packed {
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic [7:0] scratch_reg;
		logic [7:0] xon_char_one;
		logic [7:0] xon_char_two;
		logic [7:0] xoff_char_one;
		logic [7:0] xoff_char_two;
	} persist_t;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_XON, SEQ_XOFF} seq_t;

	typedef struct packed {
		logic [7:0] interrupt_enable_reg;
		logic [7:0] isr_w;
		logic [7:0] fifo_control_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] fractional_divisor_reg;
		logic [7:0] enhanced_feature_control;
		logic [7:0] halt_resume_level_reg;
		logic [7:0] trigger_level_reg;
		logic [7:0] rdata;
		logic [3:0] msr_delta;
		logic [3:0] modem_prev;
		logic spc_flag;
		logic xoff_flag;
		logic xoff_hold;
		seq_t seq;
		logic rts_n;
		logic dtr_n;
		logic irq_n;
		logic tx_allow;
		logic srst;
	} main_t;

endpackage

/* File: uart_efc_sync.sv */
`timescale 1ns/1ps
module uart_efc_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Async reset, active high
	input wire logic i_ce, // Clock enable
	input wire logic [W-1:0] i_d, // Asynchronous input
	output logic [W-1:0] o_q // Filtered synchronous value
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t st_reg;
	sync_t st_next;

	// A bit changes only once the second and third stages agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = i_d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.q[i] = st_reg.s3[i];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= {INIT, INIT, INIT, INIT};
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.q;
endmodule

/* File: uart_efc_buf.sv */
`timescale 1ns/1ps
module uart_efc_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Async reset, active high
	input wire logic i_ce, // Clock enable
	input wire logic i_in_valid, // Word offered
	input wire logic [W-1:0] i_in_data, // Offered word
	output logic o_in_ready, // Room for a word
	output logic o_out_valid, // Word available
	output logic [W-1:0] o_out_data, // Oldest word
	input wire logic i_out_ready // Drain side takes the word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// Count is one bit wider than the pointers so that a full buffer is not read as empty
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} buf_t;

	buf_t st_reg;
	buf_t st_next;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	always_comb begin
		st_next = st_reg;
		push = i_in_valid && (st_reg.cnt != FULL);
		pop = i_out_ready && (st_reg.cnt != '0);
		if (push) begin
			st_next.mem[st_reg.wp] = i_in_data;
			st_next.wp = bump(st_reg.wp);
		end
		if (pop) begin
			st_next.rp = bump(st_reg.rp);
		end
		if (push && !pop) begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_in_ready = (st_reg.cnt != FULL);
	assign o_out_valid = (st_reg.cnt != '0);
	assign o_out_data = st_reg.mem[st_reg.rp];
endmodule

/* File: uart_efc.sv */
// Functional notes
// - Protected bits writable only with enhanced enable
// - Clearing enable freezes protected bits
// - Reset clears protected bits (TCR loads 0f) and fractional divisor
// - Special detect compares second xoff, flags
// - Compare bit 0 is received LSB
// - First pair mode: both functions independent
// - Second pair mode: xoff_char_two dropped, interrupts
// - Auto request: trigger interrupt, halt deasserts
// - Auto request reasserts below resume level
// - Without auto, request is plain output
// - Auto clear-to-send pauses transmitter
// - Four readable writable flow characters
// - Power-up divisor high zero, low one
// - Modem status: inverted inputs, deltas cleared
// - Divisor, scratch, characters reset at power-up
`timescale 1ns/1ps
`include "uart_efc_regs.svh"
module uart_efc
	import uart_efc_pkg::*;
#(
	parameter int FILL_W = 7,
	parameter int BUF_DEPTH = 2
) (
	input wire logic i_clk, // 25 MHz clock
	input wire logic i_rst, // Hardware reset, async, active high
	input wire logic i_por, // Power-up reset, async, active high
	input wire logic i_ce, // Clock enable, freezes all state when low
	input wire logic i_reg_wr, // Register write strobe
	input wire logic i_reg_rd, // Register read strobe
	input wire logic [4:0] i_reg_addr, // Register index
	input wire logic [7:0] i_reg_wdata, // Write data
	output logic [7:0] o_reg_rdata, // Read data, valid cycle after read
	input wire logic i_rx_valid, // Received character offered
	input wire logic [7:0] i_rx_data, // Received character
	output logic o_rx_ready, // Character accepted when valid
	output logic o_fifo_valid, // Character for the receive FIFO
	output logic [7:0] o_fifo_data, // Character for the receive FIFO
	input wire logic i_fifo_ready, // Receive FIFO takes the character
	input wire logic [FILL_W-1:0] i_rx_fill, // Receive FIFO fill count
	input wire logic i_cts_n, // Clear-to-send pin, active low
	input wire logic i_dsr_n, // Data-set-ready pin, active low
	input wire logic i_ri_n, // Ring pin, active low
	input wire logic i_cd_n, // Carrier pin, active low
	output logic o_rts_n, // Request-to-send pin, active low
	output logic o_dtr_n, // Data-terminal-ready pin, active low
	output logic o_irq_n, // Interrupt, active low
	output logic o_tx_allow, // Transmitter may start a character
	output logic [15:0] o_divisor, // Integer baud divisor
	output logic [7:0] o_frac_divisor // Fractional divisor and sampling
);
	// ****************************************
	// Types and reset values
	// ****************************************
	localparam main_t MAIN_RST = '{
		interrupt_enable_reg: `R_ZERO, isr_w: `R_ZERO, fifo_control_reg: `R_ZERO, modem_control_reg: `R_ZERO,
		fractional_divisor_reg: `R_ZERO, enhanced_feature_control: `R_ZERO, halt_resume_level_reg: `R_TCR, trigger_level_reg: `R_ZERO,
		rdata: `R_ZERO, msr_delta: 4'h0, modem_prev: 4'hf,
		spc_flag: 1'b0, xoff_flag: 1'b0, xoff_hold: 1'b0, seq: SEQ_IDLE,
		rts_n: 1'b1, dtr_n: 1'b1, irq_n: 1'b1, tx_allow: 1'b1, srst: 1'b0
	};
	localparam persist_t PERS_RST = '{
		dll: `R_DLL, divisor_high_byte: `R_DLM, scratch_reg: `R_SPR,
		xon_char_one: `R_XCHR, xon_char_two: `R_XCHR, xoff_char_one: `R_XCHR, xoff_char_two: `R_XCHR
	};

	main_t st_reg;
	main_t st_next;
	persist_t pr_reg;
	persist_t pr_next;

	logic [3:0] modem_n;
	logic buf_in_valid;
	logic rx_take;
	logic spc_hit;
	logic drop;
	logic pend;
	logic wr_en;
	logic rd_en;
	logic enh;
	logic [FILL_W-1:0] halt_lvl;
	logic [FILL_W-1:0] resume_lvl;
	logic [FILL_W-1:0] trig_lvl;
	logic [7:0] isr_val;

	// Merge a write into a register, holding masked bits unless unlocked
	function automatic logic [7:0] guarded(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask, input logic unlock);
		guarded = unlock ? wd : ((old & mask) | (wd & ~mask));
	endfunction

	// Level fields count groups of four entries
	function automatic logic [FILL_W-1:0] level(input logic [3:0] f);
		level = FILL_W'({f, 2'b00} >> (2 - `LVL_SHIFT));
	endfunction

	// ****************************************
	// Pin synchroniser and receive buffer
	// ****************************************
	uart_efc_sync #(
		.W(4),
		.INIT(4'hf)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_d({i_cd_n, i_ri_n, i_dsr_n, i_cts_n}),
		.o_q(modem_n)
	);

	// A received character passes the buffer so a stalled FIFO loses nothing
	uart_efc_buf #(
		.W(8),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_valid(buf_in_valid),
		.i_in_data(i_rx_data),
		.o_in_ready(o_rx_ready),
		.o_out_valid(o_fifo_valid),
		.o_out_data(o_fifo_data),
		.i_out_ready(i_fifo_ready)
	);

	// ****************************************
	// Receive character inspection
	// ****************************************
	always_comb begin
		rx_take = i_rx_valid && o_rx_ready;
		// Whole-byte compare keeps bit 0 on the received LSB
		spc_hit = st_reg.enhanced_feature_control[`B_EFR_SPC] && (i_rx_data == pr_reg.xoff_char_two);
		drop = spc_hit && (st_reg.enhanced_feature_control[1:0] == `RXFC_PAIR2);
		buf_in_valid = i_rx_valid && !drop;
	end

	// ****************************************
	// Levels and interrupt
	// ****************************************
	always_comb begin
		halt_lvl = level(st_reg.halt_resume_level_reg[3:0]);
		resume_lvl = level(st_reg.halt_resume_level_reg[7:4]);
		trig_lvl = level(st_reg.trigger_level_reg[7:4]);
		if (trig_lvl == '0) begin
			trig_lvl = FILL_W'(1);
		end
		pend = (st_reg.interrupt_enable_reg[`B_IER_SPC] && (st_reg.spc_flag || st_reg.xoff_flag)) ||
			(st_reg.interrupt_enable_reg[`B_IER_RXD] && (i_rx_fill >= trig_lvl));
		isr_val = {2'b00, st_reg.isr_w[5:4] | {st_reg.xoff_flag, st_reg.spc_flag},
			3'b000, !pend};
		enh = st_reg.enhanced_feature_control[`B_EFR_ENH];
		wr_en = i_reg_wr;
		rd_en = i_reg_rd;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		pr_next = pr_reg;

		// Register writes
		if (wr_en) begin
			case (i_reg_addr)
				`A_IER: st_next.interrupt_enable_reg = guarded(st_reg.interrupt_enable_reg, i_reg_wdata, `M_IER, enh);
				`A_ISR: st_next.isr_w = guarded(st_reg.isr_w, i_reg_wdata & `M_ISR, `M_ISR, enh);
				`A_FCR: st_next.fifo_control_reg = guarded(st_reg.fifo_control_reg, i_reg_wdata, `M_FCR, enh);
				`A_MCR: st_next.modem_control_reg = guarded(st_reg.modem_control_reg, i_reg_wdata, `M_MCR, enh);
				`A_DLD: st_next.fractional_divisor_reg = guarded(st_reg.fractional_divisor_reg, i_reg_wdata, `M_ALL, enh);
				`A_TCR: st_next.halt_resume_level_reg = guarded(st_reg.halt_resume_level_reg, i_reg_wdata, `M_ALL, enh);
				`A_TLR: st_next.trigger_level_reg = guarded(st_reg.trigger_level_reg, i_reg_wdata, `M_ALL, enh);
				`A_EFR: st_next.enhanced_feature_control = i_reg_wdata;
				`A_SPR: pr_next.scratch_reg = i_reg_wdata;
				`A_DLL: pr_next.dll = i_reg_wdata;
				`A_DLM: pr_next.divisor_high_byte = i_reg_wdata;
				`A_XON_CHAR_ONE: pr_next.xon_char_one = i_reg_wdata;
				`A_XON_CHAR_TWO: pr_next.xon_char_two = i_reg_wdata;
				`A_XOFF_CHAR_ONE: pr_next.xoff_char_one = i_reg_wdata;
				`A_XOFF_CHAR_TWO: pr_next.xoff_char_two = i_reg_wdata;
				default: ;
			endcase
		end

		// Register reads; reading clears the flags that the read reports
		if (rd_en) begin
			case (i_reg_addr)
				`A_IER: st_next.rdata = st_reg.interrupt_enable_reg;
				`A_ISR: begin
					st_next.rdata = isr_val;
					st_next.spc_flag = 1'b0;
					st_next.xoff_flag = 1'b0;
				end
				`A_FCR: st_next.rdata = st_reg.fifo_control_reg;
				`A_MCR: st_next.rdata = st_reg.modem_control_reg;
				`A_LSR: st_next.rdata = `R_LSR | {7'h00, o_fifo_valid};
				`A_MSR: begin
					st_next.rdata = {~modem_n, st_reg.msr_delta};
					st_next.msr_delta = 4'h0;
				end
				`A_SPR: st_next.rdata = pr_reg.scratch_reg;
				`A_DLL: st_next.rdata = pr_reg.dll;
				`A_DLM: st_next.rdata = pr_reg.divisor_high_byte;
				`A_DLD: st_next.rdata = st_reg.fractional_divisor_reg;
				`A_EFR: st_next.rdata = st_reg.enhanced_feature_control;
				`A_TCR: st_next.rdata = st_reg.halt_resume_level_reg;
				`A_TLR: st_next.rdata = st_reg.trigger_level_reg;
				`A_XON_CHAR_ONE: st_next.rdata = pr_reg.xon_char_one;
				`A_XON_CHAR_TWO: st_next.rdata = pr_reg.xon_char_two;
				`A_XOFF_CHAR_ONE: st_next.rdata = pr_reg.xoff_char_one;
				`A_XOFF_CHAR_TWO: st_next.rdata = pr_reg.xoff_char_two;
				default: st_next.rdata = `R_ZERO;
			endcase
		end

		// Modem deltas: a change in the same cycle as the read is kept
		st_next.modem_prev = modem_n;
		st_next.msr_delta = st_next.msr_delta | (modem_n ^ st_reg.modem_prev);

		// Receive flow control and special character events
		if (rx_take) begin
			if (spc_hit) begin
				st_next.spc_flag = 1'b1;
			end
			case (st_reg.enhanced_feature_control[1:0])
				`RXFC_PAIR1: begin
					if (i_rx_data == pr_reg.xoff_char_one) begin
						st_next.xoff_hold = 1'b1;
						st_next.xoff_flag = 1'b1;
					end else if (i_rx_data == pr_reg.xon_char_one) begin
						st_next.xoff_hold = 1'b0;
					end
				end
				`RXFC_PAIR2: begin
					if (i_rx_data == pr_reg.xoff_char_two) begin
						st_next.xoff_hold = 1'b1;
						st_next.xoff_flag = 1'b1;
					end else if (i_rx_data == pr_reg.xon_char_two) begin
						st_next.xoff_hold = 1'b0;
					end
				end
				`RXFC_BOTH: begin
					// Two-character sequences: first half arms, second half acts
					case (st_reg.seq)
						SEQ_XOFF: begin
							if (i_rx_data == pr_reg.xoff_char_two) begin
								st_next.xoff_hold = 1'b1;
								st_next.xoff_flag = 1'b1;
							end
							st_next.seq = SEQ_IDLE;
						end
						SEQ_XON: begin
							if (i_rx_data == pr_reg.xon_char_two) begin
								st_next.xoff_hold = 1'b0;
							end
							st_next.seq = SEQ_IDLE;
						end
						default: begin
							if (i_rx_data == pr_reg.xoff_char_one) begin
								st_next.seq = SEQ_XOFF;
							end else if (i_rx_data == pr_reg.xon_char_one) begin
								st_next.seq = SEQ_XON;
							end
						end
					endcase
				end
				default: begin
					st_next.xoff_hold = 1'b0;
					st_next.seq = SEQ_IDLE;
				end
			endcase
		end

		// Request-to-send
		if (!st_reg.enhanced_feature_control[`B_EFR_ARTS] || !st_reg.modem_control_reg[`B_MCR_RTS]) begin
			st_next.rts_n = !st_reg.modem_control_reg[`B_MCR_RTS];
		end else if (i_rx_fill >= halt_lvl) begin
			st_next.rts_n = 1'b1;
		end else if (i_rx_fill < resume_lvl) begin
			st_next.rts_n = 1'b0;
		end

		// Clear-to-send and software flow pause the transmitter
		st_next.tx_allow = !(st_reg.enhanced_feature_control[`B_EFR_ACTS] && modem_n[0]) && !st_reg.xoff_hold;
		st_next.dtr_n = !st_reg.modem_control_reg[`B_MCR_DTR];
		st_next.irq_n = !pend;

		// Software reset request, applied next cycle; persistent set untouched
		st_next.srst = wr_en && (i_reg_addr == `A_IOCTL) && i_reg_wdata[`B_IOCTL_SRST];
		if (st_reg.srst) begin
			st_next = MAIN_RST;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst or posedge i_por) begin
		if (i_rst || i_por) begin
			st_reg <= MAIN_RST;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	// Only power-up clears these, so a board reset keeps the integer divisor
	always_ff @(posedge i_clk or posedge i_por) begin
		if (i_por) begin
			pr_reg <= PERS_RST;
		end else if (i_ce) begin
			pr_reg <= pr_next;
		end
	end

	assign o_reg_rdata = st_reg.rdata;
	assign o_rts_n = st_reg.rts_n;
	assign o_dtr_n = st_reg.dtr_n;
	assign o_irq_n = st_reg.irq_n;
	assign o_tx_allow = st_reg.tx_allow;
	assign o_divisor = {pr_reg.divisor_high_byte, pr_reg.dll};
	assign o_frac_divisor = st_reg.fractional_divisor_reg;
endmodule

/* File: uart_efc_monitor.sv */
`timescale 1ns/1ps
`include "uart_efc_regs.svh"
module uart_efc_monitor #(
	parameter int FILL_W = 7
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst, // Reset
	input wire logic i_por, // Power-up reset
	input wire logic i_ce, // Enable
	input wire logic i_reg_wr, // Write
	input wire logic i_reg_rd, // Read
	input wire logic [4:0] i_reg_addr, // Index
	input wire logic [7:0] i_reg_wdata, // Write data
	input wire logic [7:0] o_reg_rdata, // Read data
	input wire logic i_rx_valid, // Char offered
	input wire logic [7:0] i_rx_data, // Char
	input wire logic o_rx_ready, // Char taken
	input wire logic o_fifo_valid, // Char out
	input wire logic [7:0] o_fifo_data, // Char out
	input wire logic i_fifo_ready, // Sink ready
	input wire logic [FILL_W-1:0] i_rx_fill, // Fill
	input wire logic i_cts_n, // Clear-to-send
	input wire logic o_rts_n, // Request-to-send
	input wire logic o_dtr_n, // Terminal ready
	input wire logic o_irq_n, // Interrupt
	input wire logic o_tx_allow // Transmit gate
);
	// ****
	// Shadow of the host writes
	// ****
	typedef struct packed {
		logic [7:0] enhanced_feature_control;
		logic [7:0] halt_resume_level_reg;
		logic [7:0] xoff_char_two;
		logic mcr1;
		logic ier5;
		logic srst;
	} shadow_t;
	shadow_t sh_reg, sh_next;
	logic wr_en, auto_on, take;
	logic [FILL_W-1:0] halt_lvl, resume_lvl;
	assign wr_en = i_ce && i_reg_wr;
	assign auto_on = i_ce && sh_reg.enhanced_feature_control[`B_EFR_ARTS] && sh_reg.mcr1;
	assign take = i_ce && i_rx_valid && o_rx_ready;
	assign halt_lvl = FILL_W'({sh_reg.halt_resume_level_reg[3:0], 2'b00});
	assign resume_lvl = FILL_W'({sh_reg.halt_resume_level_reg[7:4], 2'b00});
	always_comb begin
		sh_next = sh_reg;
		if (wr_en) begin
			case (i_reg_addr)
				`A_EFR: sh_next.enhanced_feature_control = i_reg_wdata;
				`A_TCR: if (sh_reg.enhanced_feature_control[`B_EFR_ENH]) sh_next.halt_resume_level_reg = i_reg_wdata;
				`A_XOFF_CHAR_TWO: sh_next.xoff_char_two = i_reg_wdata;
				`A_MCR: sh_next.mcr1 = i_reg_wdata[`B_MCR_RTS];
				`A_IER: if (sh_reg.enhanced_feature_control[`B_EFR_ENH]) sh_next.ier5 = i_reg_wdata[`B_IER_SPC];
				default: ;
			endcase
		end
		// Soft reset lands one cycle after its write, characters kept
		sh_next.srst = wr_en && i_reg_addr == `A_IOCTL && i_reg_wdata[`B_IOCTL_SRST];
		if (sh_reg.srst) sh_next = {8'h00, `R_TCR, sh_reg.xoff_char_two, 3'b000};
	end
	// Characters survive the hardware reset, so only power-up clears them
	always_ff @(posedge i_clk or posedge i_rst or posedge i_por) begin
		if (i_por) sh_reg <= {8'h00, `R_TCR, 8'h00, 3'b000};
		else if (i_rst) sh_reg <= {8'h00, `R_TCR, sh_reg.xoff_char_two, 3'b000};
		else sh_reg <= sh_next;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst || i_por);
	chk_reset_pins: assert property ($fell(i_rst || i_por) |-> o_rts_n && o_dtr_n && o_tx_allow)
		else $error("outputs not high after reset");
	chk_tcr_locked: assert property (i_ce && i_reg_rd && !i_reg_wr && i_reg_addr == `A_TCR |=> o_reg_rdata == $past(sh_reg.halt_resume_level_reg))
		else $error("halt resume level wrong");
	chk_rts_manual: assert property (wr_en && !sh_reg.enhanced_feature_control[`B_EFR_ARTS] && i_reg_addr == `A_MCR |-> ##2 o_rts_n == !$past(i_reg_wdata[1], 2))
		else $error("request pin not software driven");
	chk_rts_halt: assert property (auto_on && i_rx_fill >= halt_lvl |=> o_rts_n)
		else $error("request not dropped at halt level");
	chk_rts_resume: assert property (auto_on && i_rx_fill < resume_lvl |=> !o_rts_n)
		else $error("request not restored below resume level");
	chk_rts_hold: assert property (auto_on && i_rx_fill >= resume_lvl && i_rx_fill < halt_lvl |=> $stable(o_rts_n))
		else $error("request moved between levels");
	chk_cts_stop: assert property ((i_ce && sh_reg.enhanced_feature_control[`B_EFR_ACTS] && i_cts_n)[*6] |-> !o_tx_allow)
		else $error("transmitter not paused");
	chk_spc_irq: assert property (take && sh_reg.enhanced_feature_control[`B_EFR_SPC] && sh_reg.ier5 && i_rx_data == sh_reg.xoff_char_two |-> ##2 !o_irq_n)
		else $error("special character interrupt missing");
	chk_fifo_hold: assert property (i_ce && o_fifo_valid && !i_fifo_ready |=> o_fifo_valid && $stable(o_fifo_data))
		else $error("output word lost under stall");
	cov_halt: cover property (auto_on && o_rts_n);
	cov_cts: cover property (!o_tx_allow);
	cov_irq: cover property (!o_irq_n);
endmodule

bind uart_efc uart_efc_monitor #(.FILL_W(FILL_W)) uart_efc_monitor_inst (.i_clk, .i_rst, .i_por,
	.i_ce, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_rx_valid, .i_rx_data,
	.o_rx_ready, .o_fifo_valid, .o_fifo_data, .i_fifo_ready, .i_rx_fill, .i_cts_n, .o_rts_n,
	.o_dtr_n, .o_irq_n, .o_tx_allow);

/* File: uart_efc_partner.sv */
`timescale 1ns/1ps
module uart_efc_partner (
	input wire logic i_clk, // Clock
	input wire logic i_rts_n, // Request-to-send from device
	input wire logic i_rx_ready, // Device takes the character
	input wire logic i_cts_req, // Bench asks for a pause
	output logic o_rx_valid, // Character offered
	output logic [7:0] o_rx_data, // Character
	output logic o_cts_n // Clear-to-send to device
);
	// ****
	// Remote sender
	// ****
	logic [7:0] q[$];
	logic taken;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_cts_n = 1'b0;
		taken = 1'b0;
	end
	always @(posedge i_clk) taken <= o_rx_valid && i_rx_ready;
	// No new character while the device holds request-to-send high
	always @(negedge i_clk) begin
		o_cts_n <= i_cts_req;
		if (taken) begin
			o_rx_valid <= 1'b0;
			o_rx_data <= ~o_rx_data;
		end else if (!o_rx_valid && q.size() > 0 && !i_rts_n) begin
			o_rx_valid <= 1'b1;
			o_rx_data <= q.pop_front();
		end
	end
endmodule

/* File: uart_enhanced_flow_control_tb.sv */
`timescale 1ns/1ps
`include "uart_efc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module uart_enhanced_flow_control_tb;
	logic i_clk, i_rst, i_por, i_ce, i_reg_wr, i_reg_rd, i_fifo_ready, cts_req;
	logic [4:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata, i_rx_data, o_fifo_data;
	logic i_rx_valid, o_rx_ready, o_fifo_valid, i_cts_n, o_rts_n, o_dtr_n, o_irq_n, o_tx_allow;
	logic [6:0] i_rx_fill;
	logic [15:0] o_divisor;
	logic dsr_n, ri_n, cd_n;
	logic [7:0] frac;
	logic [7:0] got[$];
	int error_cnt, n_tests, k;
	localparam logic [4:0] RA [0:16] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h1f};
	localparam logic [7:0] RV [0:16] = '{8'h00, 8'h01, 8'h00, 8'h60, 8'h50, 8'hff, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] XC [0:3] = '{8'h11, 8'h12, 8'h13, 8'h01};
	uart_efc uart_efc_inst (.i_clk, .i_rst, .i_por, .i_ce, .i_reg_wr, .i_reg_rd, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .i_rx_valid, .i_rx_data, .o_rx_ready, .o_fifo_valid,
		.o_fifo_data, .i_fifo_ready, .i_rx_fill, .i_cts_n, .i_dsr_n(dsr_n), .i_ri_n(ri_n),
		.i_cd_n(cd_n), .o_rts_n, .o_dtr_n, .o_irq_n, .o_tx_allow, .o_divisor,
		.o_frac_divisor(frac));
	uart_efc_partner uart_efc_partner_inst (.i_clk, .i_rts_n(o_rts_n), .i_rx_ready(o_rx_ready),
		.i_cts_req(cts_req), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_cts_n(i_cts_n));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_fifo_valid && i_fifo_ready && !i_rst) got.push_back(o_fifo_data);
	// ****
	// Access tasks
	// ****
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(negedge i_clk);
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		@(negedge i_clk);
		i_reg_rd = 1'b0;
		`CHK($sformatf("reg %h", a), e & m, o_reg_rdata & m)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic pop(input logic [7:0] e);
		for (int j = 0; j < 30 && got.size() == 0; j++) @(negedge i_clk);
		`CHK("fifo", e, (got.size() > 0) ? got.pop_front() : 8'hxx)
	endtask
	task automatic lvl(input logic [6:0] f, input logic r, input logic q);
		i_rx_fill = f;
		cyc(2);
		`CHK("rts", r, o_rts_n)
		`CHK("irq", q, o_irq_n)
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		wrap_up();
	end
	// ****
	// Tests
	// ****
	initial begin
		{i_rst, i_por, i_ce, i_reg_wr, i_reg_rd, i_fifo_ready, cts_req} = 7'b1110010;
		{i_reg_addr, i_reg_wdata, i_rx_fill} = '0;
		{dsr_n, ri_n, cd_n} = 3'b101;
		repeat (20) @(posedge i_clk);
		@(negedge i_clk);
		{i_rst, i_por} = 2'b00;
		for (k = 0; k < 17; k++) rd(RA[k], RV[k], (RA[k] == `A_MSR) ? 8'hf0 : 8'hff);
		`CHK("divisor", 16'h0001, o_divisor)
		`CHK("pins", 4'hf, {o_rts_n, o_dtr_n, o_irq_n, o_tx_allow})
		wr(`A_MCR, 8'h03);
		wr(`A_TCR, 8'h21);
		wr(`A_IER, 8'hf0);
		wr(`A_DLD, 8'h35);
		rd(`A_TCR, 8'h0f);
		rd(`A_IER, 8'h00);
		rd(`A_DLD, 8'h00);
		wr(`A_EFR, 8'h10);
		wr(`A_TCR, 8'h21);
		wr(`A_IER, 8'h20);
		wr(`A_DLD, 8'h35);
		rd(`A_DLD, 8'h35);
		`CHK("frac", 8'h35, frac)
		wr(`A_EFR, 8'h00);
		wr(`A_TCR, 8'h99);
		wr(`A_IER, 8'h00);
		rd(`A_TCR, 8'h21);
		rd(`A_IER, 8'h20);
		for (k = 0; k < 4; k++) wr(5'(`A_XON_CHAR_ONE + k), XC[k]);
		for (k = 0; k < 4; k++) rd(5'(`A_XON_CHAR_ONE + k), XC[k]);
		wr(`A_SPR, 8'h5a);
		wr(`A_DLL, 8'h07);
		wr(`A_EFR, 8'h30);
		uart_efc_partner_inst.q.push_back(8'h80);
		pop(8'h80);
		rd(`A_ISR, 8'h01);
		uart_efc_partner_inst.q.push_back(8'h01);
		pop(8'h01);
		cyc(2);
		`CHK("irq", 1'b0, o_irq_n)
		rd(`A_ISR, 8'h10);
		rd(`A_ISR, 8'h01);
		wr(`A_EFR, 8'h31);
		uart_efc_partner_inst.q.push_back(8'h01);
		cyc(8);
		`CHK("dropped", 0, got.size())
		rd(`A_ISR, 8'h30);
		`CHK("tx", 1'b0, o_tx_allow)
		uart_efc_partner_inst.q.push_back(8'h12);
		pop(8'h12);
		cyc(3);
		`CHK("tx", 1'b1, o_tx_allow)
		wr(`A_EFR, 8'h30);
		wr(`A_EFR, 8'h32);
		uart_efc_partner_inst.q.push_back(8'h01);
		pop(8'h01);
		rd(`A_ISR, 8'h10);
		uart_efc_partner_inst.q.push_back(8'h13);
		pop(8'h13);
		cyc(3);
		rd(`A_ISR, 8'h20, 8'hfe);
		`CHK("tx", 1'b0, o_tx_allow)
		uart_efc_partner_inst.q.push_back(8'h11);
		pop(8'h11);
		cyc(3);
		`CHK("tx", 1'b1, o_tx_allow)
		wr(`A_EFR, 8'h10);
		wr(`A_IER, 8'h01);
		wr(`A_TCR, 8'h12);
		wr(`A_TLR, 8'h20);
		wr(`A_MCR, 8'h00);
		lvl(7'd0, 1'b1, 1'b1);
		wr(`A_MCR, 8'h02);
		lvl(7'd0, 1'b0, 1'b1);
		wr(`A_EFR, 8'h50);
		lvl(7'd7, 1'b0, 1'b1);
		lvl(7'd8, 1'b1, 1'b0);
		lvl(7'd5, 1'b1, 1'b1);
		lvl(7'd3, 1'b0, 1'b1);
		wr(`A_MCR, 8'h00);
		lvl(7'd0, 1'b1, 1'b1);
		wr(`A_MCR, 8'h03);
		wr(`A_EFR, 8'h90);
		cts_req = 1'b1;
		cyc(8);
		`CHK("tx", 1'b0, o_tx_allow)
		cts_req = 1'b0;
		cyc(8);
		`CHK("tx", 1'b1, o_tx_allow)
		// Sink stalls: two words held, the third waits at the sender
		i_fifo_ready = 1'b0;
		for (k = 0; k < 3; k++) uart_efc_partner_inst.q.push_back(8'(8'ha1 + k));
		cyc(12);
		`CHK("rx_ready", 1'b0, o_rx_ready)
		i_fifo_ready = 1'b1;
		for (k = 0; k < 3; k++) pop(8'(8'ha1 + k));
		i_rst = 1'b1;
		cyc(2);
		i_rst = 1'b0;
		`CHK("pins", 4'hf, {o_rts_n, o_dtr_n, o_irq_n, o_tx_allow})
		`CHK("divisor", 16'h0007, o_divisor)
		rd(`A_SPR, 8'h5a);
		rd(`A_XOFF_CHAR_TWO, 8'h01);
		rd(`A_EFR, 8'h00);
		rd(`A_TCR, 8'h0f);
		rd(`A_MSR, 8'h50, 8'hf0);
		ri_n = 1'b1;
		cyc(6);
		rd(`A_MSR, 8'h14);
		// Soft reset restores control, keeps the persistent set
		wr(`A_EFR, 8'h10);
		wr(`A_TCR, 8'h21);
		wr(`A_IOCTL, 8'h08);
		cyc(1);
		rd(`A_TCR, 8'h0f);
		rd(`A_DLL, 8'h07);
		// Clock enable low freezes a write
		i_ce = 1'b0;
		wr(`A_SPR, 8'h33);
		i_ce = 1'b1;
		rd(`A_SPR, 8'h5a);
		wrap_up();
	end
endmodule
